// file: design/lp_baud_gen.sv
`timescale 1ns/1ns
`default_nettype none

module lp_baud_gen
  import lp_divisor_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  lp_baud_if.gen bif // Divisor input and tick outputs
);

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  logic [15:0] div_cnt_reg; // Cycles counted so far in one 16x period
  logic [15:0] div_cnt_next;
  logic [3:0] os_cnt_reg; // 16x ticks within one baud period
  logic [3:0] os_cnt_next;
  logic tick16_reg; // Registered 16x tick
  logic tick16_next;
  logic baud_reg; // Registered baud tick
  logic baud_next;

  // Next-state for the divider chain
  always_comb begin
    div_cnt_next = div_cnt_reg;
    os_cnt_next = os_cnt_reg;
    tick16_next = 1'b0;
    baud_next = 1'b0;
    if (bif.divisor == 16'h0000) begin
      // Held idle so a new divisor starts a clean period
      div_cnt_next = 16'h0000;
      os_cnt_next = 4'h0;
    end else if (div_cnt_reg >= bif.divisor - 16'h0001) begin
      div_cnt_next = 16'h0000;
      tick16_next = 1'b1;
      if (os_cnt_reg == OVERSAMPLE_LAST) begin
        os_cnt_next = 4'h0;
        baud_next = 1'b1;
      end else begin
        os_cnt_next = os_cnt_reg + 4'h1;
      end
    end else begin
      // Count on; a lowered divisor ends the period early
      div_cnt_next = div_cnt_reg + 16'h0001;
    end
  end

  // Register the divider chain
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt_reg <= 16'h0000;
      os_cnt_reg <= 4'h0;
      tick16_reg <= 1'b0;
      baud_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      os_cnt_reg <= os_cnt_next;
      tick16_reg <= tick16_next;
      baud_reg <= baud_next;
    end
  end

  assign bif.tick16 = tick16_reg;
  assign bif.baud_tick = baud_reg;

endmodule

`default_nettype wire

// file: design/lp_baud_if.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// Divisor in, divided ticks out
// ---------------------------------------------------------------
interface lp_baud_if;
  logic [15:0] divisor; // Programmed 16-bit divisor
  logic tick16; // One pulse per divisor cycles
  logic baud_tick; // One pulse per 16 times divisor cycles

  modport ctrl (output divisor, input tick16, input baud_tick);
  modport gen (input divisor, output tick16, output baud_tick);
endinterface

`default_nettype wire

// file: design/lp_divisor_pkg.sv
`default_nettype none

package lp_divisor_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] LINE_CONTROL_OFFSET = 32'h5000_110C;
  localparam logic [31:0] LP_DIV_LOW_OFFSET = 32'h5000_1120;
  localparam logic [31:0] LP_DIV_HIGH_OFFSET = 32'h5000_1124;
  localparam logic [31:0] IR_MODE_OFFSET = 32'h5000_1128;
  localparam logic [31:0] LP_STATUS_OFFSET = 32'h5000_112C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DIVISOR_LATCH_ACCESS_BIT = 7;
  localparam int IR_LOW_POWER_EN_BIT = 0;
  localparam int STAT_CLK_ACTIVE_BIT = 0;
  localparam int STAT_PULSE_SEEN_BIT = 1;
  localparam int BYTE_W = 8;
  localparam int DIV_W = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] LP_DIV_LOW_RESET = 8'h00;
  localparam logic [7:0] LP_DIV_HIGH_RESET = 8'h00;
  localparam logic IR_MODE_RESET = 1'b0;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  // Last 16x tick count in one baud period; the oversampling ratio is one more, 16
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_LINE_CTRL = 3'b001,
    SEL_DIV_LOW = 3'b010,
    SEL_DIV_HIGH = 3'b011,
    SEL_IR_MODE = 3'b100,
    SEL_STATUS = 3'b101
  } reg_sel_t;

endpackage

`default_nettype wire

// file: design/lp_divisor_top.sv
`timescale 1ns/1ns
`default_nettype none

module lp_divisor_top (
  input wire logic core_clk, // System clock, 125 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write when high
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic ir_rx_pulse, // Infrared receive pulse, high active
  output logic ir_pulse_valid, // One cycle per accepted pulse
  output logic lp_baud_tick, // Low-power baud clock tick
  output logic lp_clk_active // Low-power baud clock running
);
  import lp_divisor_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  lp_baud_if bif (); // Link to the divider

  logic [7:0] line_control_reg; // Line control byte, bit 7 opens latch
  logic [7:0] line_control_next;
  logic [7:0] div_low_reg; // Divisor bits 7:0
  logic [7:0] div_low_next;
  logic [7:0] div_high_reg; // Divisor bits 15:8
  logic [7:0] div_high_next;
  logic ir_mode_reg; // Low-power infrared mode enable
  logic ir_mode_next;
  logic pulse_seen_reg; // Sticky, cleared by a status read
  logic pulse_seen_next;
  logic [31:0] prdata_reg; // Read data
  logic [31:0] prdata_next;
  logic pready_reg; // Ready, one access cycle late
  logic pready_next;
  logic pslverr_reg; // Error for unmapped address
  logic pslverr_next;
  logic ir_prev_reg; // Pulse input one cycle ago
  logic ir_prev_next;
  logic tick_seen_reg; // A 16x tick fell inside the pulse
  logic tick_seen_next;
  logic ir_valid_reg; // Accepted pulse strobe
  logic ir_valid_next;
  logic baud_reg; // Retimed baud tick
  logic active_reg; // Retimed clock-active flag

  reg_sel_t sel; // Decoded register
  logic latch_open; // Latch access bit
  logic divisor_nonzero; // Any divisor bit set
  logic commit; // Transfer completes this edge

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Map a byte address to a register
  function automatic reg_sel_t decode(input logic [31:0] addr);
    reg_sel_t s;
    s = SEL_NONE;
    unique case (addr)
      LINE_CONTROL_OFFSET: s = SEL_LINE_CTRL;
      LP_DIV_LOW_OFFSET: s = SEL_DIV_LOW;
      LP_DIV_HIGH_OFFSET: s = SEL_DIV_HIGH;
      IR_MODE_OFFSET: s = SEL_IR_MODE;
      LP_STATUS_OFFSET: s = SEL_STATUS;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction

  // Place a byte in the low lane, upper bits zero
  function automatic logic [31:0] widen(input logic [7:0] b);
    return {24'h00_0000, b};
  endfunction

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  assign bif.divisor = {div_high_reg, div_low_reg};

  lp_baud_gen u_gen (
    .core_clk (core_clk),
    .rst (rst),
    .bif (bif)
  );

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  assign sel = decode(paddr);
  assign latch_open = line_control_reg[DIVISOR_LATCH_ACCESS_BIT];
  assign divisor_nonzero = (bif.divisor != 16'h0000);
  // Writes and read side effects land at the ready edge only
  assign commit = psel & penable & pready_reg;

  // Next values for the bus answer and the software registers
  always_comb begin
    line_control_next = line_control_reg;
    div_low_next = div_low_reg;
    div_high_next = div_high_reg;
    ir_mode_next = ir_mode_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    // Ready one cycle into the access phase, then drop
    pready_next = psel & penable & ~pready_reg;
    if (psel & penable & ~pready_reg) begin
      // Read data prepared the cycle before ready
      prdata_next = 32'h0000_0000;
      pslverr_next = (sel == SEL_NONE);
      if (!pwrite) begin
        unique case (sel)
          SEL_LINE_CTRL: prdata_next = widen(line_control_reg);
          SEL_DIV_LOW: prdata_next = latch_open ?
                         widen(div_low_reg) : 32'h0000_0000;
          SEL_DIV_HIGH: prdata_next = latch_open ?
                          widen(div_high_reg) : 32'h0000_0000;
          SEL_IR_MODE: prdata_next = {31'h0000_0000, ir_mode_reg};
          SEL_STATUS: begin
            prdata_next[STAT_CLK_ACTIVE_BIT] = divisor_nonzero;
            prdata_next[STAT_PULSE_SEEN_BIT] = pulse_seen_reg;
          end
          // Unmapped reads zero with an error
          SEL_NONE: prdata_next = 32'h0000_0000;
          default: prdata_next = 32'h0000_0000;
        endcase
      end
    end
    if (commit & pwrite) begin
      unique case (sel)
        SEL_LINE_CTRL: line_control_next = pwdata[BYTE_W-1:0];
        SEL_DIV_LOW: begin
          if (latch_open) div_low_next = pwdata[BYTE_W-1:0];
        end
        SEL_DIV_HIGH: begin
          if (latch_open) div_high_next = pwdata[BYTE_W-1:0];
        end
        SEL_IR_MODE: ir_mode_next = pwdata[IR_LOW_POWER_EN_BIT];
        // Status is read-only; unmapped writes are dropped
        SEL_STATUS: ir_mode_next = ir_mode_reg;
        SEL_NONE: ir_mode_next = ir_mode_reg;
        default: ir_mode_next = ir_mode_reg;
      endcase
    end
  end

  // Register the software-visible state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      line_control_reg <= LINE_CONTROL_RESET;
      div_low_reg <= LP_DIV_LOW_RESET;
      div_high_reg <= LP_DIV_HIGH_RESET;
      ir_mode_reg <= IR_MODE_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      line_control_reg <= line_control_next;
      div_low_reg <= div_low_next;
      div_high_reg <= div_high_next;
      ir_mode_reg <= ir_mode_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ---------------------------------------------------------------
  // Infrared pulse detection
  // ---------------------------------------------------------------
  // Pulse qualification; the width check only bites in low-power
  // mode, where a pulse must straddle at least one 16x tick. A
  // glitch during which no 16x tick occurs is thus rejected.
  always_comb begin
    ir_prev_next = ir_rx_pulse;
    tick_seen_next = tick_seen_reg;
    ir_valid_next = 1'b0;
    pulse_seen_next = pulse_seen_reg;
    if (!divisor_nonzero) begin
      tick_seen_next = 1'b0;
    end else begin
      if (ir_rx_pulse & ~ir_prev_reg) begin
        // New pulse starts the width check afresh
        tick_seen_next = bif.tick16;
      end else if (ir_rx_pulse) begin
        tick_seen_next = tick_seen_reg | bif.tick16;
      end else if (ir_prev_reg) begin
        // Falling edge ends the pulse
        // low-power mode needs a tick
        ir_valid_next = ~ir_mode_reg | tick_seen_reg;
        tick_seen_next = 1'b0;
      end
    end
    // Clear on status read; a new pulse in that cycle wins
    if (commit & ~pwrite & (sel == SEL_STATUS)) begin
      pulse_seen_next = 1'b0;
    end
    if (ir_valid_next) begin
      pulse_seen_next = 1'b1;
    end
  end

  // Register the detector and retime divider outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ir_prev_reg <= 1'b0;
      tick_seen_reg <= 1'b0;
      ir_valid_reg <= 1'b0;
      pulse_seen_reg <= 1'b0;
      baud_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      ir_prev_reg <= ir_prev_next;
      tick_seen_reg <= tick_seen_next;
      ir_valid_reg <= ir_valid_next;
      pulse_seen_reg <= pulse_seen_next;
      baud_reg <= bif.baud_tick;
      active_reg <= divisor_nonzero;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ir_pulse_valid = ir_valid_reg;
  assign lp_baud_tick = baud_reg;
  assign lp_clk_active = active_reg;

endmodule

`default_nettype wire

// file: testbench/lp_divisor_props.sv
`timescale 1ns/1ns
`default_nettype none

module lp_divisor_props
  import lp_divisor_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Direction
  input wire logic [31:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic ir_rx_pulse, // Infrared input
  input wire logic ir_pulse_valid, // Accepted pulse
  input wire logic lp_baud_tick, // Baud tick
  input wire logic lp_clk_active // Clock running
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  logic mapped; // Address hits a register
  assign mapped = paddr inside {LINE_CONTROL_OFFSET, LP_DIV_LOW_OFFSET,
    LP_DIV_HIGH_OFFSET, IR_MODE_OFFSET, LP_STATUS_OFFSET};
  AST_ONE_WAIT: assert property (
    $rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_MAP: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  AST_UPPER_ZERO: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("reserved read bits not zero");
  AST_RESET_OUT: assert property (
    $past(rst) |-> !pready && !pslverr && !lp_baud_tick &&
    !lp_clk_active && !ir_pulse_valid)
    else $error("outputs not clear after reset");
  // ----------------------------------------
  // Divider and pulses
  // ----------------------------------------
  // no baud tick in the eight cycles after one
  AST_TICK_GAP: assert property (
    lp_baud_tick |=> !lp_baud_tick [*8])
    else $error("baud ticks too close");
  AST_TICK_ACTIVE: assert property (
    lp_baud_tick |-> lp_clk_active || $past(lp_clk_active))
    else $error("tick while clock stopped");
  AST_ZERO_QUIET: assert property (
    !lp_clk_active [*4] |-> !ir_pulse_valid)
    else $error("pulse accepted with zero divisor");
  AST_PULSE_FALL: assert property (
    ir_pulse_valid |-> !$past(ir_rx_pulse))
    else $error("pulse flagged before input fell");
endmodule

bind lp_divisor_top lp_divisor_props u_props (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ir_rx_pulse(ir_rx_pulse), .ir_pulse_valid(ir_pulse_valid),
  .lp_baud_tick(lp_baud_tick), .lp_clk_active(lp_clk_active));

`default_nettype wire

// file: testbench/uart_ir_low_power_divisor_tb.sv
`timescale 1ns/1ns
`default_nettype none

module uart_ir_low_power_divisor_tb;
  import lp_divisor_pkg::*;
  logic core_clk = 1'b0; // 125 MHz clock
  logic rst = 1'b1; // Held 4 cycles
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Bus control
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata; // Bus data
  logic pready, pslverr, ir_pulse_valid, lp_baud_tick, lp_clk_active;
  logic ir_rx_pulse = 1'b0; // Light on the receiver
  integer num_errors = 0, num_checks = 0, seed = 39378, cyc = 0;
  integer ticks = 0, last_tick = 0, pulses = 0; // Monitor counts
  logic [31:0] rd, wv, a; // Read data, random value, address
  logic err; // Error flag of last transfer
  logic [15:0] dvs [3] = '{16'h0003, 16'h0101, 16'h0001}; // Divisors

  lp_divisor_top dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ir_rx_pulse(ir_rx_pulse), .ir_pulse_valid(ir_pulse_valid),
    .lp_baud_tick(lp_baud_tick), .lp_clk_active(lp_clk_active));

  always #4 core_clk = ~core_clk;

  // Count ticks and accepted pulses
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    pulses <= pulses + (ir_pulse_valid === 1'b1);
    if (lp_baud_tick === 1'b1) begin
      ticks <= ticks + 1;
      last_tick <= cyc;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Ready and data taken at the rising edge that ends the transfer
  task automatic apb(input logic wr, input logic [31:0] ad, dat);
    integer n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= dat;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n == 20) check(32'h0, 32'h1, "no ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic integer exp_period(input logic [15:0] dv);
    return 16 * dv;
  endfunction
  task automatic set_div(input logic [15:0] dv);
    apb(1'b1, LP_DIV_LOW_OFFSET, {24'h0, dv[7:0]});
    apb(1'b1, LP_DIV_HIGH_OFFSET, {24'h0, dv[15:8]});
    // Settle time before the divided clock is trusted
    repeat (8) @(posedge core_clk);
    apb(1'b0, LP_STATUS_OFFSET, 32'h0);
    check(rd[STAT_CLK_ACTIVE_BIT], dv != 16'h0, "status active");
  endtask
  // Bounded wait for the next tick
  task automatic wait_tick;
    integer n;
    n = ticks;
    repeat (20000) if (ticks == n) @(posedge core_clk);
  endtask
  task automatic pulse(input integer len, exp);
    integer p;
    p = pulses;
    @(posedge core_clk);
    ir_rx_pulse <= 1'b1;
    repeat (len) @(posedge core_clk);
    ir_rx_pulse <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(pulses - p, exp, "pulse count");
    // Sticky flag follows the pulse, and the read clears it
    apb(1'b0, LP_STATUS_OFFSET, 32'h0);
    check(rd[STAT_PULSE_SEEN_BIT], exp != 0, "pulse seen");
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    integer t0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    // Latch closed: write dropped, read zero without error
    apb(1'b1, LP_DIV_LOW_OFFSET, 32'h0000_00AB);
    apb(1'b0, LP_DIV_LOW_OFFSET, 32'h0);
    check(rd, 32'h0, "closed read");
    check(err, 1'b0, "closed error");
    apb(1'b1, LINE_CONTROL_OFFSET, 32'h0000_0080);
    apb(1'b0, LP_DIV_LOW_OFFSET, 32'h0);
    check(rd, 32'h0, "closed write kept");
    apb(1'b0, LP_DIV_HIGH_OFFSET, 32'h0);
    check(rd, {24'h0, LP_DIV_HIGH_RESET}, "reset high");
    for (int i = 0; i < 8; i++) begin
      wv = $random(seed);
      a = i[0] ? LP_DIV_HIGH_OFFSET : LP_DIV_LOW_OFFSET;
      apb(1'b1, a, wv);
      apb(1'b0, a, 32'h0);
      check(rd, {24'h0, wv[7:0]}, "byte rw");
    end
    apb(1'b0, LP_STATUS_OFFSET + 32'h4, 32'h0);
    check(rd, 32'h0, "unmapped data");
    check(err, 1'b1, "unmapped error");
    foreach (dvs[i]) begin
      set_div(dvs[i]);
      wait_tick;
      wait_tick;
      t0 = last_tick;
      wait_tick;
      check(last_tick - t0, exp_period(dvs[i]), "tick period");
      check(lp_clk_active, 1'b1, "clock running");
    end
    pulse(3, 1);
    apb(1'b1, IR_MODE_OFFSET, 32'h0000_0001);
    // Nearest divisor to 115.2 kbaud from a 125 MHz clock
    set_div(16'h0044);
    pulse(140, 1);
    // Short pulse just after a tick misses the next one
    wait_tick;
    pulse(2, 0);
    set_div(16'h0000);
    t0 = ticks;
    repeat (100) @(posedge core_clk);
    check(ticks - t0, 32'h0, "zero divisor ticks");
    check(lp_clk_active, 1'b0, "zero divisor idle");
    pulse(20, 0);
    apb(1'b1, IR_MODE_OFFSET, 32'h0);
    pulse(20, 0);
    end_sim;
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge core_clk);
    check(32'h0, 32'h1, "watchdog");
    end_sim;
  end
endmodule

`default_nettype wire
